// ---- rpot_pkg.sv ----
// Shared constants, types and register map for the pulsed-off relay timer
package rpot_pkg;

    // Clock and tick timing
    localparam int unsigned CLK_HZ      = 40_000_000;
    localparam int unsigned TICK_MS     = 100;
    localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;

    // Interval counters: 16 bits of 0.1 s ticks reach 6553.5 s
    localparam int unsigned CNT_W = 16;

    // AXI4-Lite geometry and answers
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_BRK   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_OFF   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ON    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STAT  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h14;

    // Field positions
    localparam int unsigned CTRL_MODE_LSB  = 0;
    localparam int unsigned STAT_RELAY_BIT = 0;
    localparam int unsigned STAT_TRIP_BIT  = 1;
    localparam int unsigned STAT_STATE_LSB = 4;

    // Pulsed-off timer modes
    typedef enum logic [1:0] {
        RPOT_ONE_SHOT_OFF,
        RPOT_PULSE_OFF,
        RPOT_REPEAT_OFF,
        RPOT_MODE_RSVD
    } rpot_mode_t;

    // Sequencer states
    typedef enum logic [2:0] {
        RPOT_IDLE,
        RPOT_BREAK,
        RPOT_OFF,
        RPOT_ON,
        RPOT_ARM
    } rpot_state_t;

    // Programmed settings
    typedef struct packed {
        rpot_mode_t       mode;
        logic [CNT_W-1:0] brk;
        logic [CNT_W-1:0] off_t;
        logic [CNT_W-1:0] on_t;
    } rpot_cfg_t;

    // Reset values of the settings
    localparam rpot_mode_t       RST_MODE  = RPOT_ONE_SHOT_OFF;
    localparam logic [CNT_W-1:0] RST_BRK   = 16'h0000;
    localparam logic [CNT_W-1:0] RST_OFF_T = 16'h0000;
    localparam logic [CNT_W-1:0] RST_ON_T  = 16'h0000;

endpackage : rpot_pkg

// ---- rpot_tick.sv ----
// Periodic single-cycle tick strobe divided from the system clock
`timescale 1ns/1ps
`default_nettype none
module rpot_tick
    import rpot_pkg::*;
#(
    parameter int unsigned DIV = TICK_CYCLES
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    output var  logic tick
);

    logic [31:0] div_ff;
    logic [31:0] nxt_div;
    logic        tick_ff;
    logic        nxt_tick;

    // Count DIV cycles, strobe on wrap
    always_comb begin
        nxt_div  = div_ff + 32'h0000_0001;
        nxt_tick = 1'b0;
        if (div_ff >= DIV - 1) begin
            nxt_div  = 32'h0000_0000;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_ff  <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (ce) begin
            div_ff  <= nxt_div;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule : rpot_tick
`default_nettype wire

// ---- rpot_top.sv ----
// Pulsed-off relay timer sequencer with AXI4-Lite settings registers
//
// How it works
// - In every pulsed-off mode the relay rests energized and the first de-energize pulse starts only on trip deactivation.
// - In one-shot off mode the relay stays energized after deactivation until the break delay has elapsed.
// - In one-shot off mode the relay is then de-energized for at least the minimum off interval.
// - In one-shot off mode a trip activation during the minimum off interval waits for its end, then energizes.
// - In pulse off mode the relay stays energized after deactivation until the break delay times out.
// - In pulse off mode the relay is then de-energized for at most the maximum off interval, then energized.
// - In pulse off mode a new pulse needs the trip point to go active and then inactive again.
// - In pulse off mode a trip activation during the off interval waits for its expiry, then energizes.
// - In repeat off mode deactivation first holds the relay off for the off interval, then on for the on interval.
// - In repeat off mode the end of the on interval de-energizes and restarts the off interval while inactive.
// - In repeat off mode any trip activation energizes the relay at once and abandons the cycle.
// - All intervals are timed in 0.1 s steps up to 6553.5 s.
// - A zero break delay switches the relay with no delay.
`timescale 1ns/1ps
`default_nettype none
module rpot_top
    import rpot_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    input  wire logic              trip_point_active,
    output var  logic              relay_energize,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [DATA_W-1:0] s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // Byte-lane merge of a write into a 32-bit register image
    function automatic logic [31:0] merge_strb(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_strb

    // Register offset decode, shared by read and write paths
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == OFS_CTRL) || (a == OFS_BRK) || (a == OFS_OFF) ||
               (a == OFS_ON) || (a == OFS_STAT) || (a == OFS_COUNT);
    endfunction : is_mapped

    // ------------------------------------------------------------------
    // Tick strobe
    // ------------------------------------------------------------------
    logic tick;

    rpot_tick #(
        .DIV (TICK_DIV)
    ) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .tick    (tick)
    );

    // ------------------------------------------------------------------
    // Trip point synchroniser; only trip_s2_ff feeds logic
    // ------------------------------------------------------------------
    logic trip_s1_ff;
    logic trip_s2_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trip_s1_ff <= 1'b1;
            trip_s2_ff <= 1'b1;
        end else if (ce) begin
            trip_s1_ff <= trip_point_active;
            trip_s2_ff <= trip_s1_ff;
        end
    end

    // ------------------------------------------------------------------
    // Settings and bus state
    // ------------------------------------------------------------------
    rpot_cfg_t         cfg_ff;
    rpot_cfg_t         nxt_cfg;
    logic              awready_ff;
    logic              nxt_awready;
    logic              wready_ff;
    logic              nxt_wready;
    logic              bvalid_ff;
    logic              nxt_bvalid;
    logic [1:0]        bresp_ff;
    logic [1:0]        nxt_bresp;
    logic              arready_ff;
    logic              nxt_arready;
    logic              rvalid_ff;
    logic              nxt_rvalid;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic [1:0]        rresp_ff;
    logic [1:0]        nxt_rresp;

    // Sequencer state, declared here for the status read
    rpot_state_t       state_ff;
    rpot_state_t       nxt_state;
    logic              relay_ff;
    logic              nxt_relay;
    logic [CNT_W-1:0]  cnt_ff;
    logic [CNT_W-1:0]  nxt_cnt;

    logic              wr_fire;
    logic              rd_fire;
    logic [31:0]       wr_img;
    logic [31:0]       rd_img;

    // Address and data are taken together, so no skid buffer is needed
    assign wr_fire = awready_ff && s_axi_awvalid && wready_ff && s_axi_wvalid;
    assign rd_fire = arready_ff && s_axi_arvalid;

    // Current image of the addressed register
    always_comb begin
        rd_img = 32'h0000_0000;
        unique case (s_axi_araddr)
            OFS_CTRL:  rd_img[CTRL_MODE_LSB +: 2] = cfg_ff.mode;
            OFS_BRK:   rd_img[CNT_W-1:0] = cfg_ff.brk;
            OFS_OFF:   rd_img[CNT_W-1:0] = cfg_ff.off_t;
            OFS_ON:    rd_img[CNT_W-1:0] = cfg_ff.on_t;
            OFS_STAT: begin
                rd_img[STAT_RELAY_BIT]      = relay_ff;
                rd_img[STAT_TRIP_BIT]       = trip_s2_ff;
                rd_img[STAT_STATE_LSB +: 3] = state_ff;
            end
            OFS_COUNT: rd_img[CNT_W-1:0] = cnt_ff;
            default:   rd_img = 32'h0000_0000;
        endcase
    end

    // Write side: accept both channels in one cycle, then respond
    always_comb begin
        nxt_cfg     = cfg_ff;
        nxt_awready = 1'b0;
        nxt_wready  = 1'b0;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        wr_img      = 32'h0000_0000;
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (!awready_ff && !bvalid_ff && s_axi_awvalid && s_axi_wvalid) begin
            nxt_awready = 1'b1;
            nxt_wready  = 1'b1;
        end
        if (wr_fire) begin
            nxt_bvalid = 1'b1;
            nxt_bresp  = is_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_awaddr)
                OFS_CTRL: begin
                    wr_img = merge_strb({30'h0000_0000, cfg_ff.mode},
                                        s_axi_wdata, s_axi_wstrb);
                    // Reserved mode code leaves the current mode in place
                    if (wr_img[CTRL_MODE_LSB +: 2] != RPOT_MODE_RSVD) begin
                        nxt_cfg.mode = rpot_mode_t'(wr_img[CTRL_MODE_LSB +: 2]);
                    end
                end
                OFS_BRK: begin
                    wr_img = merge_strb({16'h0000, cfg_ff.brk}, s_axi_wdata, s_axi_wstrb);
                    nxt_cfg.brk = wr_img[CNT_W-1:0];
                end
                OFS_OFF: begin
                    wr_img = merge_strb({16'h0000, cfg_ff.off_t}, s_axi_wdata, s_axi_wstrb);
                    nxt_cfg.off_t = wr_img[CNT_W-1:0];
                end
                OFS_ON: begin
                    wr_img = merge_strb({16'h0000, cfg_ff.on_t}, s_axi_wdata, s_axi_wstrb);
                    nxt_cfg.on_t = wr_img[CNT_W-1:0];
                end
                default: wr_img = 32'h0000_0000;
            endcase
        end
    end

    // Read side: one address phase cycle, then data held until taken
    always_comb begin
        nxt_arready = 1'b0;
        nxt_rvalid  = rvalid_ff;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (!arready_ff && !rvalid_ff && s_axi_arvalid) begin
            nxt_arready = 1'b1;
        end
        if (rd_fire) begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = rd_img;
            nxt_rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_ff     <= '{mode: RST_MODE, brk: RST_BRK, off_t: RST_OFF_T, on_t: RST_ON_T};
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RESP_OKAY;
        end else if (ce) begin
            cfg_ff     <= nxt_cfg;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    // ------------------------------------------------------------------
    // Relay sequencer
    // ------------------------------------------------------------------
    logic             restart;
    logic [CNT_W-1:0] target;
    logic             done;
    logic             skip_ff;
    logic             nxt_skip;

    // Interval length for the running phase
    always_comb begin
        unique case (state_ff)
            RPOT_BREAK: target = cfg_ff.brk;
            RPOT_ON:    target = cfg_ff.on_t;
            default:    target = cfg_ff.off_t;
        endcase
    end

    // Counting up against a live setting; a setting lowered below the
    // count ends the phase on the next cycle instead of wrapping
    assign done = (cnt_ff >= target);

    always_comb begin
        nxt_state = state_ff;
        nxt_relay = relay_ff;
        restart   = 1'b0;
        unique case (state_ff)
            // Resting energized, waiting for deactivation
            RPOT_IDLE: begin
                nxt_relay = 1'b1;
                if (!trip_s2_ff) begin
                    restart = 1'b1;
                    if (cfg_ff.mode == RPOT_REPEAT_OFF) begin
                        nxt_state = RPOT_OFF;
                        nxt_relay = 1'b0;
                    end else if (cfg_ff.brk == 16'h0000) begin
                        nxt_state = RPOT_OFF;
                        nxt_relay = 1'b0;
                    end else begin
                        nxt_state = RPOT_BREAK;
                    end
                end
            end
            // Energized through the break delay; reactivation cancels it
            RPOT_BREAK: begin
                if (trip_s2_ff) begin
                    nxt_state = RPOT_IDLE;
                end else if (done) begin
                    nxt_state = RPOT_OFF;
                    nxt_relay = 1'b0;
                    restart   = 1'b1;
                end
            end
            // De-energized interval
            RPOT_OFF: begin
                unique case (cfg_ff.mode)
                    RPOT_REPEAT_OFF: begin
                        if (trip_s2_ff) begin
                            nxt_state = RPOT_IDLE;
                            nxt_relay = 1'b1;
                        end else if (done) begin
                            nxt_state = RPOT_ON;
                            nxt_relay = 1'b1;
                            restart   = 1'b1;
                        end
                    end
                    RPOT_PULSE_OFF: begin
                        // Never longer than the interval, whatever the trip does
                        if (done) begin
                            nxt_relay = 1'b1;
                            nxt_state = trip_s2_ff ? RPOT_IDLE : RPOT_ARM;
                        end
                    end
                    default: begin
                        // One-shot: stays off past the minimum until reactivation
                        if (done && trip_s2_ff) begin
                            nxt_relay = 1'b1;
                            nxt_state = RPOT_IDLE;
                        end
                    end
                endcase
            end
            // Energized part of the repeat cycle
            RPOT_ON: begin
                if (trip_s2_ff) begin
                    nxt_state = RPOT_IDLE;
                end else if (done) begin
                    nxt_state = RPOT_OFF;
                    nxt_relay = 1'b0;
                    restart   = 1'b1;
                end
            end
            // Pulse spent; needs reactivation before another pulse
            RPOT_ARM: begin
                nxt_relay = 1'b1;
                if (trip_s2_ff) begin
                    nxt_state = RPOT_IDLE;
                end
            end
            default: begin
                nxt_state = RPOT_IDLE;
                nxt_relay = 1'b1;
            end
        endcase
    end

    // Interval counter: cleared at phase start, saturates at full scale.
    // The first tick after a restart ends a partial period and is not
    // counted, so a phase of N ticks never runs short of N full periods.
    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_skip = skip_ff;
        if (restart) begin
            nxt_cnt  = 16'h0000;
            nxt_skip = 1'b1;
        end else if (tick && skip_ff) begin
            nxt_skip = 1'b0;
        end else if (tick && (cnt_ff != 16'hFFFF)) begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= RPOT_IDLE;
            relay_ff <= 1'b1;
            cnt_ff   <= 16'h0000;
            skip_ff  <= 1'b1;
        end else if (ce) begin
            state_ff <= nxt_state;
            relay_ff <= nxt_relay;
            cnt_ff   <= nxt_cnt;
            skip_ff  <= nxt_skip;
        end
    end

    // Outputs straight from flip-flops
    assign relay_energize = relay_ff;
    assign s_axi_awready  = awready_ff;
    assign s_axi_wready   = wready_ff;
    assign s_axi_bvalid   = bvalid_ff;
    assign s_axi_bresp    = bresp_ff;
    assign s_axi_arready  = arready_ff;
    assign s_axi_rvalid   = rvalid_ff;
    assign s_axi_rdata    = rdata_ff;
    assign s_axi_rresp    = rresp_ff;

endmodule : rpot_top
`default_nettype wire

// ---- rpot_trip_model.sv ----
// Setpoint comparator stand-in driving the trip level
`timescale 1ns/1ps
`default_nettype none
module rpot_trip_model (
    input  wire logic aclk,
    input  wire logic trip_cmd,
    output var  logic trip_point_active
);
    // Comparator starts active so the relay rests energized
    initial trip_point_active = 1'b1;
    // Level moves just after an edge, like a sampled comparator
    always @(posedge aclk) begin
        trip_point_active <= trip_cmd;
    end
endmodule : rpot_trip_model
`default_nettype wire

// ---- rpot_checker.sv ----
// Bus and relay assertions for the pulsed-off relay timer
`timescale 1ns/1ps
`default_nettype none
module rpot_checker
    import rpot_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              trip_point_active,
    input wire logic              relay_energize,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready
);
    // One domain, so clock and reset are stated once
    default clocking dcb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reset_idle: assert property ($rose(aresetn) |-> relay_energize
        && !s_axi_bvalid && !s_axi_rvalid) else $error("not idle after reset");
    // Relay may only drop if the trip level was low in at least one of the two to four cycles before
    a_fall_after_low: assert property ($fell(relay_energize) |->
        (!$past(trip_point_active, 2) || !$past(trip_point_active, 3)
        || !$past(trip_point_active, 4))) else $error("relay dropped while trip high");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready)
        else $error("address and data ready split");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_ready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("read ready held");
endmodule : rpot_checker

bind rpot_top rpot_checker u_chk (.aclk, .aresetn, .trip_point_active, .relay_energize,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ---- relay_pulsed_off_timer_test.sv ----
// Self-checking bench for the pulsed-off relay timer
`timescale 1ns/1ps
`default_nettype none
module relay_pulsed_off_timer_test
    import rpot_pkg::*;
;
    logic              aclk, aresetn, ce, trip_cmd, trip_point_active, relay_energize;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, d;
    logic [2:0]        s_axi_awprot, s_axi_arprot;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready;
    logic [33:0]       wr_q[$], rd_q[$];
    logic [7:0]        regs[3];
    int                n_fail, num_checks, cyc;

    // Short tick so each 0.1 s step is ten clocks
    rpot_top #(.TICK_DIV(10)) dut (.aclk, .aresetn, .ce, .trip_point_active,
        .relay_energize, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    rpot_trip_model u_trip (.aclk, .trip_cmd, .trip_point_active);

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic test_done();
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end

    // Responses are matched against the oldest note of their channel
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) check("bresp", {s_axi_bresp, 32'h0000_0000}, wr_q.pop_front());
        if (s_axi_rvalid && s_axi_rready) check("rdata", {s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    end

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] rsp);
        wr_q.push_back({rsp, 32'h0000_0000});
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] exp);
        rd_q.push_back(exp);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    // Relay must reach level v no sooner than lo and no later than hi clocks
    task automatic wait_relay(input logic v, input int lo, input int hi);
        int t;
        t = 0;
        while (relay_energize !== v && t <= hi) begin
            @(posedge aclk);
            t++;
        end
        check("relay_delay", 34'(t >= lo && t <= hi), 34'h1);
    endtask : wait_relay

    task automatic hold_relay(input logic v, input int n);
        logic ok;
        ok = 1'b1;
        repeat (n) begin
            @(posedge aclk);
            ok &= (relay_energize === v);
        end
        check("relay_hold", 34'(ok), 34'h1);
    endtask : hold_relay

    initial begin
        d = $urandom(32'hfce589f9);
        {aresetn, ce, trip_cmd} = 3'b011;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00f;
        regs = '{OFS_BRK, OFS_OFF, OFS_ON};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Register map: reset values, refusals, random round trips
        rd(OFS_CTRL, {RESP_OKAY, 32'h0000_0000});
        rd(OFS_STAT, {RESP_OKAY, 32'h0000_0003});
        rd(OFS_COUNT, {RESP_OKAY, 32'h0000_0000});
        rd(8'h18, {RESP_SLVERR, 32'h0000_0000});
        wr(8'h18, $urandom, RESP_SLVERR);
        wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
        rd(OFS_CTRL, {RESP_OKAY, 32'h0000_0000});
        for (int i = 0; i < 3; i++) begin
            d = $urandom;
            rd(regs[i], {RESP_OKAY, 32'h0000_0000});
            wr(regs[i], d, RESP_OKAY);
            rd(regs[i], {RESP_OKAY, 16'h0000, d[15:0]});
        end
        // One-shot off: break 2 ticks, minimum off 3 ticks, trip back early
        wr(OFS_BRK, 32'h0000_0002, RESP_OKAY);
        wr(OFS_OFF, 32'h0000_0003, RESP_OKAY);
        wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
        trip_cmd <= 1'b0;
        wait_relay(1'b0, 22, 38);
        trip_cmd <= 1'b1;
        wait_relay(1'b1, 27, 46);
        // Pulse off: break 1 tick, maximum off 2 ticks
        wr(OFS_BRK, 32'h0000_0001, RESP_OKAY);
        wr(OFS_OFF, 32'h0000_0002, RESP_OKAY);
        wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
        rd(OFS_CTRL, {RESP_OKAY, 32'h0000_0001});
        trip_cmd <= 1'b0;
        wait_relay(1'b0, 12, 26);
        wait_relay(1'b1, 18, 34);
        hold_relay(1'b1, 60);
        rd(OFS_STAT, {RESP_OKAY, 25'h0, 3'(RPOT_ARM), 4'h1});
        wr(OFS_BRK, 32'h0000_0000, RESP_OKAY);
        trip_cmd <= 1'b1;
        hold_relay(1'b1, 8);
        trip_cmd <= 1'b0;
        wait_relay(1'b0, 2, 8);
        trip_cmd <= 1'b1;
        wait_relay(1'b1, 18, 34);
        // Repeat off: off 1 tick, on 2 ticks, three full cycles then trip back
        wr(OFS_OFF, 32'h0000_0001, RESP_OKAY);
        wr(OFS_ON, 32'h0000_0002, RESP_OKAY);
        wr(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
        trip_cmd <= 1'b0;
        wait_relay(1'b0, 2, 8);
        wait_relay(1'b1, 8, 24);
        repeat (2) begin
            wait_relay(1'b0, 18, 34);
            wait_relay(1'b1, 8, 24);
        end
        wait_relay(1'b0, 18, 34);
        trip_cmd <= 1'b1;
        wait_relay(1'b1, 2, 7);
        // Reset in mid-cycle restores idle and clears settings
        trip_cmd <= 1'b0;
        wait_relay(1'b0, 2, 8);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("relay", 34'(relay_energize), 34'h1);
        rd(OFS_CTRL, {RESP_OKAY, 32'h0000_0000});
        test_done();
    end
endmodule : relay_pulsed_off_timer_test
`default_nettype wire
